/* File: src/lsp_ctrl.sv */
// regulator set point, mode and short-circuit protection register bank
//
// Behaviour
// - protection exists on video, audio, camera, card and three general regulators only
// - raw overload is debounced before it counts as a fault
// - protected fault clears the regulator on bit and sets the flag together
// - the mask bit gates the flag onto the interrupt output
// - protection disabled: no flag set, no regulator switched off
// - protection enable resets to cleared
// - video level codes 00..11 give 2.700, 2.775, 2.500, 2.600 V
// - audio level codes 00..11 give 2.300, 2.500, 2.775, 3.000 V
// - pll bias codes 00..11 give 1.2, 1.25, 1.5, 1.8 V
// - digital bias codes 00..11 give 1.05, 1.25, 1.65, 1.8 V
// - camera codes 00..11 give 2.5, 2.6, 2.75, 3.00 V
// - camera pass select 0 internal transistor, 1 external drive
// - camera regulator comes up disabled until software enables it
// - card codes 000..111 give 1.80 to 3.15 V ascending
// - video low power uses the internal bypass path
// - audio and video each have low power and standby options
// - standby-configured regulators go low power while standby is high
// - pull-down active while disabled or while system reset is low
// - general regulator short sets the same flag and shuts it down
`timescale 1ns/1ps
`default_nettype none
`include "lsp_map.svh"
module lsp_ctrl
  import lsp_pkg::*;
#(
  parameter int NREG     = `LSP_EN_W,
  parameter int DEBOUNCE = `LSP_DEBOUNCE_CYC
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    ce_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [`LSP_ADDR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output var  logic [31:0]             wb_dat_o,
  output var  logic                    wb_ack_o,
  input  wire logic [NREG-1:0]         overload_i,
  input  wire logic                    standby_i,
  input  wire logic                    system_reset_out_n_i,
  output var  logic [NREG-1:0]         regulator_on_o,
  output var  logic [NREG-1:0]         pull_down_o,
  output var  logic                    video_low_power_o,
  output var  logic                    video_bypass_o,
  output var  logic                    audio_low_power_o,
  output var  logic                    camera_external_drive_o,
  output var  logic [15:0]             video_supply_mv_o,
  output var  logic [15:0]             audio_supply_mv_o,
  output var  logic [15:0]             pll_bias_mv_o,
  output var  logic [15:0]             digital_bias_mv_o,
  output var  logic [15:0]             camera_supply_mv_o,
  output var  logic [15:0]             card_supply_mv_o,
  output var  logic                    short_fault_irq_o
);
  import lsp_pkg::*;

  localparam logic [NREG-1:0] PROTECTED =
    NREG'((1 << LSP_VIDEO) | (1 << LSP_AUDIO) | (1 << LSP_CAM) |
          (1 << LSP_CARD) | (1 << LSP_GEN1) | (1 << LSP_GEN2) |
          (1 << LSP_GEN3));

  // refuse a map whose fields would overlap or fall off a register
  if (NREG != `LSP_EN_W) begin : g_bad_nreg
    $error("regulator count is fixed by the map");
  end
  if (DEBOUNCE < 1) begin : g_bad_deb
    $error("debounce must be at least one cycle");
  end
  if (`LSP_LVL_CARD_LSB + 3 > `LSP_LVL_GEN1_LSB) begin : g_bad_card
    $error("card level field overlaps the next field");
  end
  if (`LSP_LVL_GEN3_LSB >= `LSP_LVL_W) begin : g_bad_level
    $error("level fields do not fit the level register");
  end
  if (`LSP_MODE_CAM_PASS >= `LSP_MODE_W) begin : g_bad_mode
    $error("mode fields do not fit the mode register");
  end
  if (`LSP_PR_FLAG >= `LSP_PR_FAULTS_LSB) begin : g_bad_prot
    $error("protect control bits overlap the fault status");
  end
  if (`LSP_PR_FAULTS_LSB + `LSP_PR_FAULTS_W > 32) begin : g_bad_stat
    $error("fault status does not fit the bus word");
  end
  if (`LSP_LVL_W > 32 || NREG > 32) begin : g_bad_word
    $error("registers wider than the bus word");
  end

  typedef struct packed {
    lsp_bus_type                  bus;
    logic                         ack;
    logic [31:0]                  rdata;
    logic [`LSP_LVL_W-1:0]        level;
    logic [NREG-1:0]              on_bit;
    logic [`LSP_MODE_W-1:0]       mode;
    logic                         protect_en;
    logic                         irq_mask;
    logic                         irq_flag;
    logic [NREG-1:0]              pull_down;
    logic                         vid_lp;
    logic                         vid_bypass;
    logic                         aud_lp;
    logic                         cam_ext;
    logic [15:0]                  vid_mv;
    logic [15:0]                  aud_mv;
    logic [15:0]                  pll_mv;
    logic [15:0]                  dig_mv;
    logic [15:0]                  cam_mv;
    logic [15:0]                  card_mv;
    logic                         irq;
  } lsp_state_type;

  lsp_state_type   st;
  lsp_state_type   next_st;
  logic [NREG-1:0] fault;

  // only protected regulators get a debouncer
  for (genvar g = 0; g < NREG; g++) begin : g_deb
    if (PROTECTED[g]) begin : g_on
      lsp_debounce #(
        .CYCLES (DEBOUNCE)
      ) u_deb (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .raw_i   (overload_i[g]),
        .fault_o (fault[g])
      );
    end else begin : g_off
      assign fault[g] = 1'b0;
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[b*8 +: 8] = wd[b*8 +: 8];
    end
    return r;
  endfunction : merge

  function automatic logic [15:0] dec2(input logic [1:0] c,
                                       input logic [15:0] v0,
                                       input logic [15:0] v1,
                                       input logic [15:0] v2,
                                       input logic [15:0] v3);
    logic [15:0] r;
    r = v0;
    unique case (c)
      2'h0: r = v0;
      2'h1: r = v1;
      2'h2: r = v2;
      2'h3: r = v3;
    endcase
    return r;
  endfunction : dec2

  logic [31:0] wr_level;
  logic [31:0] wr_enable;
  logic [31:0] wr_mode;
  logic [31:0] wr_protect;
  logic [31:0] prot_word;
  logic        access;
  logic        wr;
  logic [NREG-1:0] trip;
  logic [1:0]  vcode;
  logic [1:0]  acode;
  logic [1:0]  pcode;
  logic [1:0]  dcode;
  logic [1:0]  ccode;
  logic [2:0]  scode;
  logic        sby;

  always_comb begin
    next_st    = st;
    access     = wb_cyc_i && wb_stb_i && (st.bus == LSP_IDLE);
    // a write lands on the edge at which the master sees ack
    wr         = wb_cyc_i && wb_stb_i && wb_we_i && (st.bus == LSP_ACK);
    wr_level   = merge(32'(st.level), wb_dat_i, wb_sel_i);
    wr_enable  = merge(32'(st.on_bit), wb_dat_i, wb_sel_i);
    wr_mode    = merge(32'(st.mode), wb_dat_i, wb_sel_i);
    prot_word  = 32'h00000000;
    prot_word[`LSP_PR_ENABLE] = st.protect_en;
    prot_word[`LSP_PR_MASK]   = st.irq_mask;
    prot_word[`LSP_PR_FLAG]   = st.irq_flag;
    prot_word[`LSP_PR_FAULTS_LSB +: `LSP_PR_FAULTS_W] =
      fault[`LSP_PR_FAULTS_W-1:0];
    // status bits ride through the merge but are never stored back
    wr_protect = merge(prot_word, wb_dat_i, wb_sel_i);
    // bit by bit so an unprotected fault can never reach an on bit
    for (int i = 0; i < NREG; i++) begin
      trip[i] = fault[i] && PROTECTED[i] && st.on_bit[i];
    end

    // classic single cycle: ack one cycle after strobe, then one idle
    unique case (st.bus)
      LSP_IDLE: begin
        if (access) begin
          next_st.bus = LSP_ACK;
          next_st.ack = 1'b1;
          unique case (wb_adr_i)
            `LSP_OFF_LEVEL:   next_st.rdata = 32'(st.level);
            `LSP_OFF_ENABLE:  next_st.rdata = 32'(st.on_bit);
            `LSP_OFF_MODE:    next_st.rdata = 32'(st.mode);
            `LSP_OFF_PROTECT: next_st.rdata = prot_word;
            default:          next_st.rdata = 32'h00000000;
          endcase
        end
      end
      LSP_ACK: begin
        next_st.bus   = LSP_IDLE;
        next_st.ack   = 1'b0;
        next_st.rdata = 32'h00000000;
      end
      default: begin
        next_st.bus = LSP_IDLE;
        next_st.ack = 1'b0;
      end
    endcase

    if (wr) begin
      unique case (wb_adr_i)
        `LSP_OFF_LEVEL:  next_st.level = wr_level[`LSP_LVL_W-1:0];
        `LSP_OFF_ENABLE: next_st.on_bit = wr_enable[NREG-1:0];
        `LSP_OFF_MODE:   next_st.mode = wr_mode[`LSP_MODE_W-1:0];
        `LSP_OFF_PROTECT: begin
          next_st.protect_en = wr_protect[`LSP_PR_ENABLE];
          next_st.irq_mask   = wr_protect[`LSP_PR_MASK];
          // write one to clear the flag
          if (wr_protect[`LSP_PR_FLAG] && wb_sel_i[0]) begin
            next_st.irq_flag = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // protection after the bus so a fault beats a same-cycle write
    if (st.protect_en && (trip != '0)) begin
      next_st.on_bit   = next_st.on_bit & ~trip;
      next_st.irq_flag = 1'b1;
    end

    sby   = standby_i;
    vcode = st.level[`LSP_LVL_VIDEO_LSB +: 2];
    acode = st.level[`LSP_LVL_AUDIO_LSB +: 2];
    pcode = st.level[`LSP_LVL_PLL_LSB +: 2];
    dcode = st.level[`LSP_LVL_DIG_LSB +: 2];
    ccode = st.level[`LSP_LVL_CAM_LSB +: 2];
    scode = st.level[`LSP_LVL_CARD_LSB +: 3];

    next_st.vid_lp = st.mode[`LSP_MODE_VID_LP] ||
                     (st.mode[`LSP_MODE_VID_SBY] && sby);
    next_st.aud_lp = st.mode[`LSP_MODE_AUD_LP] ||
                     (st.mode[`LSP_MODE_AUD_SBY] && sby);
    next_st.vid_bypass = next_st.vid_lp;
    next_st.cam_ext    = st.mode[`LSP_MODE_CAM_PASS];

    // set points kept in millivolts so a monitor reads them directly
    next_st.vid_mv = dec2(vcode, 16'h0A8C, 16'h0AD7,
                          16'h09C4, 16'h0A28);
    next_st.aud_mv = dec2(acode, 16'h08FC, 16'h09C4,
                          16'h0AD7, 16'h0BB8);
    next_st.pll_mv = dec2(pcode, 16'h04B0, 16'h04E2,
                          16'h05DC, 16'h0708);
    next_st.dig_mv = dec2(dcode, 16'h041A, 16'h04E2,
                          16'h0672, 16'h0708);
    next_st.cam_mv = dec2(ccode, 16'h09C4, 16'h0A28,
                          16'h0ABE, 16'h0BB8);
    unique case (scode)
      3'h0: next_st.card_mv = 16'h0708;
      3'h1: next_st.card_mv = 16'h07D0;
      3'h2: next_st.card_mv = 16'h0A28;
      3'h3: next_st.card_mv = 16'h0A8C;
      3'h4: next_st.card_mv = 16'h0AF0;
      3'h5: next_st.card_mv = 16'h0B54;
      3'h6: next_st.card_mv = 16'h0BB8;
      3'h7: next_st.card_mv = 16'h0C4E;
    endcase

    // pull-down taken from the next on bit, so it changes on the same edge as the output
    next_st.pull_down = ~next_st.on_bit |
                        {NREG{~system_reset_out_n_i}};
    next_st.irq = next_st.irq_flag && !next_st.irq_mask;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st            <= '0;
      st.bus        <= LSP_IDLE;
      st.ack        <= 1'b0;
      st.rdata      <= 32'h00000000;
      st.level      <= `LSP_LVL_RESET;
      st.on_bit     <= `LSP_EN_RESET;
      st.mode       <= `LSP_MODE_RESET;
      st.protect_en <= 1'b0;
      st.irq_mask   <= `LSP_MASK_RESET;
      st.irq_flag   <= 1'b0;
      st.irq        <= 1'b0;
      // pull-downs on and set points at code 0 until software acts
      st.pull_down  <= {NREG{1'b1}};
      st.vid_lp     <= 1'b0;
      st.vid_bypass <= 1'b0;
      st.aud_lp     <= 1'b0;
      st.cam_ext    <= 1'b0;
      st.vid_mv     <= `LSP_VID_MV_RESET;
      st.aud_mv     <= `LSP_AUD_MV_RESET;
      st.pll_mv     <= `LSP_PLL_MV_RESET;
      st.dig_mv     <= `LSP_DIG_MV_RESET;
      st.cam_mv     <= `LSP_CAM_MV_RESET;
      st.card_mv    <= `LSP_CARD_MV_RESET;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign wb_ack_o                = st.ack;
  assign wb_dat_o                = st.rdata;
  assign regulator_on_o          = st.on_bit;
  assign pull_down_o             = st.pull_down;
  assign video_low_power_o       = st.vid_lp;
  assign video_bypass_o          = st.vid_bypass;
  assign audio_low_power_o       = st.aud_lp;
  assign camera_external_drive_o = st.cam_ext;
  assign video_supply_mv_o       = st.vid_mv;
  assign audio_supply_mv_o       = st.aud_mv;
  assign pll_bias_mv_o           = st.pll_mv;
  assign digital_bias_mv_o       = st.dig_mv;
  assign camera_supply_mv_o      = st.cam_mv;
  assign card_supply_mv_o        = st.card_mv;
  assign short_fault_irq_o       = st.irq;
endmodule : lsp_ctrl
`default_nettype wire

/* File: src/lsp_debounce.sv */
// debounce of one raw overload indication
`timescale 1ns/1ps
`default_nettype none
module lsp_debounce #(
  parameter int CYCLES = 250
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic raw_i,
  output var  logic fault_o
);
  localparam int CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] count;
    logic          fault;
  } lsp_deb_state_type;

  lsp_deb_state_type st;
  lsp_deb_state_type next_st;

  if (CYCLES < 1) begin : g_bad_cycles
    $error("debounce count must be at least one");
  end

  always_comb begin
    next_st = st;
    if (!raw_i) begin
      next_st.count = '0;
      next_st.fault = 1'b0;
    end else if (st.count == CW'(CYCLES - 1)) begin
      next_st.fault = 1'b1;
    end else begin
      next_st.count = st.count + CW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign fault_o = st.fault;
endmodule : lsp_debounce
`default_nettype wire

/* File: src/lsp_map.svh */
// register offsets, field positions, reset values and timing counts
`ifndef LSP_MAP_SVH
`define LSP_MAP_SVH
`define LSP_ADDR_W         4
`define LSP_OFF_LEVEL      4'h0
`define LSP_OFF_ENABLE     4'h4
`define LSP_OFF_MODE       4'h8
`define LSP_OFF_PROTECT    4'hC
`define LSP_LVL_VIDEO_LSB  0
`define LSP_LVL_AUDIO_LSB  2
`define LSP_LVL_PLL_LSB    4
`define LSP_LVL_DIG_LSB    6
`define LSP_LVL_CAM_LSB    8
`define LSP_LVL_CARD_LSB   10
`define LSP_LVL_GEN1_LSB   13
`define LSP_LVL_GEN2_LSB   15
`define LSP_LVL_GEN3_LSB   18
`define LSP_LVL_W          19
`define LSP_LVL_RESET      19'h00000
`define LSP_EN_W           10
`define LSP_EN_RESET       10'h000
`define LSP_MODE_VID_LP    0
`define LSP_MODE_VID_SBY   1
`define LSP_MODE_AUD_LP    2
`define LSP_MODE_AUD_SBY   3
`define LSP_MODE_CAM_PASS  4
`define LSP_MODE_W         5
`define LSP_MODE_RESET     5'h00
`define LSP_PR_ENABLE      0
`define LSP_PR_MASK        1
`define LSP_PR_FLAG        2
`define LSP_PR_FAULTS_LSB  8
`define LSP_PR_FAULTS_W    8
`define LSP_MASK_RESET     1'b1
`define LSP_VID_MV_RESET   16'h0A8C
`define LSP_AUD_MV_RESET   16'h08FC
`define LSP_PLL_MV_RESET   16'h04B0
`define LSP_DIG_MV_RESET   16'h041A
`define LSP_CAM_MV_RESET   16'h09C4
`define LSP_CARD_MV_RESET  16'h0708
`define LSP_DEBOUNCE_NS    1000
`define LSP_CLK_MHZ        250
`define LSP_DEBOUNCE_CYC   ((`LSP_DEBOUNCE_NS * `LSP_CLK_MHZ) / 1000)
`endif

/* File: src/lsp_pkg.sv */
// types shared by the regulator control block
package lsp_pkg;
  typedef enum logic [3:0] {
    LSP_VIDEO, LSP_AUDIO, LSP_PLL, LSP_DIG, LSP_CAM, LSP_CARD,
    LSP_GEN1, LSP_GEN2, LSP_GEN3, LSP_IOHI
  } lsp_reg_type;
  typedef enum logic [1:0] {
    LSP_IDLE, LSP_ACK
  } lsp_bus_type;
endpackage : lsp_pkg

/* File: testbench/lsp_ctrl_asserts.sv */
// port-level assertions for the regulator control block
`timescale 1ns/1ps
`default_nettype none
`include "lsp_map.svh"
module lsp_ctrl_asserts #(
  parameter int NREG     = 10,
  parameter int DEBOUNCE = 250
) (
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             ce_i,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [3:0]       wb_adr_i,
  input wire logic [3:0]       wb_sel_i,
  input wire logic [31:0]      wb_dat_i,
  input wire logic             wb_ack_o,
  input wire logic [NREG-1:0]  overload_i,
  input wire logic [NREG-1:0]  regulator_on_o,
  input wire logic [NREG-1:0]  pull_down_o,
  input wire logic             video_bypass_o,
  input wire logic             video_low_power_o,
  input wire logic             camera_external_drive_o,
  input wire logic [15:0]      video_supply_mv_o,
  input wire logic [15:0]      card_supply_mv_o,
  input wire logic             short_fault_irq_o
);
  localparam int VID[4] = '{2700, 2775, 2500, 2600};
  localparam int CRD[8] = '{1800, 2000, 2600, 2700, 2800, 2900, 3000, 3150};
  logic [7:0] run_q;
  logic       wr_q;
  // saturating run length of video overload
  always_ff @(posedge clk_i) begin
    if (rst_i || !overload_i[0]) run_q <= 8'h00;
    else if (ce_i && run_q != 8'hFF) run_q <= run_q + 8'h01;
  end
  assign wr_q = wb_ack_o && wb_we_i && ce_i;
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (wr_q |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_take_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i
    |=> wb_ack_o) else $error("request not answered");
  reset_state_a: assert property ($fell(rst_i)
    |-> regulator_on_o == '0 && !short_fault_irq_o)
    else $error("state after reset wrong");
  unprot_hold_a: assert property (
    |(~regulator_on_o & $past(regulator_on_o) & 10'h20C)
    |-> $past(wr_q)) else $error("unprotected regulator tripped");
  debounce_min_a: assert property ($fell(regulator_on_o[0])
    && !$past(wr_q) |-> $past(run_q) >= DEBOUNCE - 1)
    else $error("trip before debounce");
  pull_down_a: assert property (
    (~regulator_on_o & ~$past(regulator_on_o) & ~pull_down_o) == '0)
    else $error("pull-down off on disabled regulator");
  video_mv_a: assert property (wr_q && wb_sel_i[0]
    && wb_adr_i == `LSP_OFF_LEVEL
    |=> ##1 video_supply_mv_o == 16'(VID[$past(wb_dat_i[1:0], 2)]))
    else $error("video set point wrong");
  card_mv_a: assert property (wr_q && wb_sel_i[1]
    && wb_adr_i == `LSP_OFF_LEVEL
    |=> ##1 card_supply_mv_o == 16'(CRD[$past(wb_dat_i[12:10], 2)]))
    else $error("card set point wrong");
  cam_pass_a: assert property (wr_q && wb_sel_i[0]
    && wb_adr_i == `LSP_OFF_MODE
    |=> ##1 camera_external_drive_o == $past(wb_dat_i[4], 2))
    else $error("camera pass select wrong");
  bypass_a: assert property (video_bypass_o == video_low_power_o)
    else $error("bypass not tied to low power");
  trip_c: cover property ($fell(regulator_on_o[0]));
  irq_c: cover property ($rose(short_fault_irq_o));
  read_c: cover property (wb_ack_o && !wb_we_i);
endmodule : lsp_ctrl_asserts
`default_nettype wire

/* File: testbench/tb.sv */
// self-checking bench for the regulator control block
`timescale 1ns/1ps
`default_nettype none
`include "lsp_map.svh"
module tb;
  import lsp_pkg::*;
  localparam int DB = 4;
  logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic standby_i, system_reset_out_n_i, video_low_power_o, video_bypass_o;
  logic audio_low_power_o, camera_external_drive_o, short_fault_irq_o;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd, m;
  logic [9:0]  overload_i, regulator_on_o, pull_down_o;
  logic [15:0] video_supply_mv_o, audio_supply_mv_o, pll_bias_mv_o;
  logic [15:0] digital_bias_mv_o, camera_supply_mv_o, card_supply_mv_o;
  int err_count, samples_checked, seed, k;
  int vid[4] = '{2700, 2775, 2500, 2600};
  int aud[4] = '{2300, 2500, 2775, 3000};
  int pll[4] = '{1200, 1250, 1500, 1800};
  int dig[4] = '{1050, 1250, 1650, 1800};
  int cam[4] = '{2500, 2600, 2750, 3000};
  int crd[8] = '{1800, 2000, 2600, 2700, 2800, 2900, 3000, 3150};
  lsp_ctrl #(
    .DEBOUNCE (DB)
  ) lsp_ctrl_inst (
    .clk_i                   (clk_i),
    .rst_i                   (rst_i),
    .ce_i                    (ce_i),
    .wb_cyc_i                (wb_cyc_i),
    .wb_stb_i                (wb_stb_i),
    .wb_we_i                 (wb_we_i),
    .wb_adr_i                (wb_adr_i),
    .wb_sel_i                (wb_sel_i),
    .wb_dat_i                (wb_dat_i),
    .wb_dat_o                (wb_dat_o),
    .wb_ack_o                (wb_ack_o),
    .overload_i              (overload_i),
    .standby_i               (standby_i),
    .system_reset_out_n_i    (system_reset_out_n_i),
    .regulator_on_o          (regulator_on_o),
    .pull_down_o             (pull_down_o),
    .video_low_power_o       (video_low_power_o),
    .video_bypass_o          (video_bypass_o),
    .audio_low_power_o       (audio_low_power_o),
    .camera_external_drive_o (camera_external_drive_o),
    .video_supply_mv_o       (video_supply_mv_o),
    .audio_supply_mv_o       (audio_supply_mv_o),
    .pll_bias_mv_o           (pll_bias_mv_o),
    .digital_bias_mv_o       (digital_bias_mv_o),
    .camera_supply_mv_o      (camera_supply_mv_o),
    .card_supply_mv_o        (card_supply_mv_o),
    .short_fault_irq_o       (short_fault_irq_o)
  );
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  // holds the request until ack or for 40 cycles, never assumes a latency
  task automatic bus(input logic we, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 40) chk("ack", 32'h0, 32'h1);
  endtask : bus
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  initial begin
    #(4 * 5000);
    err_count++;
    wrap_up();
  end
  initial begin
    seed = 68064;
    {rst_i, ce_i, system_reset_out_n_i} = 3'h7;
    {wb_cyc_i, wb_stb_i, wb_we_i, standby_i} = 4'h0;
    {wb_adr_i, wb_sel_i, wb_dat_i, overload_i} = {8'h0F, 32'h0, 10'h0};
    tick(20);
    rst_i <= 1'b0;
    tick(1);
    chk("on", regulator_on_o, 32'h0);
    chk("pull", pull_down_o, 32'h3FF);
    bus(0, `LSP_OFF_PROTECT, 32'h0);
    chk("prot", rd & 32'h7, 32'h2);
    bus(1, 4'h2, 32'hFFFFFFFF);
    bus(0, 4'h2, 32'h0);
    chk("unmapped", rd, 32'h0);
    $display("test reset done");
    for (k = 0; k < 8; k++) begin
      m = ($random(seed) & 32'h7E000) | (k % 4) * 32'h155 | (k << 10);
      bus(1, `LSP_OFF_LEVEL, m);
      tick(2);
      chk("video", video_supply_mv_o, vid[k % 4]);
      chk("audio", audio_supply_mv_o, aud[k % 4]);
      chk("pll", pll_bias_mv_o, pll[k % 4]);
      chk("dig", digital_bias_mv_o, dig[k % 4]);
      chk("cam", camera_supply_mv_o, cam[k % 4]);
      chk("card", card_supply_mv_o, crd[k]);
      bus(0, `LSP_OFF_LEVEL, 32'h0);
      chk("level", rd, m);
    end
    wb_sel_i <= 4'h1;
    bus(1, `LSP_OFF_LEVEL, 32'hFFFFFFFF);
    wb_sel_i <= 4'hF;
    bus(0, `LSP_OFF_LEVEL, 32'h0);
    chk("sel", rd, m | 32'h000000FF);
    $display("test set points done");
    for (k = 0; k < 16; k++) begin
      m = $random(seed) & 32'h1F;
      standby_i <= $random(seed);
      bus(1, `LSP_OFF_MODE, m);
      tick(2);
      chk("ext", camera_external_drive_o, m[4]);
      chk("vlp", video_low_power_o, m[0] | m[1] & standby_i);
      chk("byp", video_bypass_o, m[0] | m[1] & standby_i);
      chk("alp", audio_low_power_o, m[2] | m[3] & standby_i);
    end
    $display("test modes done");
    bus(1, `LSP_OFF_ENABLE, 32'h3FF);
    overload_i <= 10'h3FF;
    tick(DB + 5);
    chk("on", regulator_on_o, 32'h3FF);
    chk("irq", short_fault_irq_o, 32'h0);
    overload_i <= 10'h0;
    bus(1, `LSP_OFF_PROTECT, 32'h1);
    overload_i <= 10'h3FF;
    tick(DB - 1);
    overload_i <= 10'h0;
    tick(2);
    chk("on", regulator_on_o, 32'h3FF);
    overload_i <= 10'h3FF;
    tick(DB + 5);
    chk("on", regulator_on_o, 32'h20C);
    chk("pull", pull_down_o, 32'h1F3);
    chk("irq", short_fault_irq_o, 32'h1);
    overload_i <= 10'h0;
    tick(3);
    chk("on", regulator_on_o, 32'h20C);
    bus(0, `LSP_OFF_PROTECT, 32'h0);
    chk("prot", rd & 32'h7, 32'h5);
    bus(1, `LSP_OFF_PROTECT, 32'h5);
    tick(2);
    chk("irq", short_fault_irq_o, 32'h0);
    bus(1, `LSP_OFF_ENABLE, 32'h3FF);
    tick(2);
    chk("on", regulator_on_o, 32'h3FF);
    system_reset_out_n_i <= 1'b0;
    tick(2);
    chk("pull", pull_down_o, 32'h3FF);
    system_reset_out_n_i <= 1'b1;
    tick(2);
    chk("pull", pull_down_o, 32'h0);
    bus(1, `LSP_OFF_PROTECT, 32'h3);
    overload_i <= 10'h40;
    tick(DB + 5);
    chk("on", regulator_on_o, 32'h3BF);
    chk("irq", short_fault_irq_o, 32'h0);
    overload_i <= 10'h0;
    bus(1, `LSP_OFF_PROTECT, 32'h1);
    tick(2);
    chk("irq", short_fault_irq_o, 32'h1);
    ce_i <= 1'b0;
    overload_i <= 10'h001;
    tick(DB + 5);
    chk("hold", regulator_on_o, 32'h3BF);
    ce_i <= 1'b1;
    tick(DB + 5);
    chk("on", regulator_on_o, 32'h3BE);
    overload_i <= 10'h0;
    bus(1, `LSP_OFF_ENABLE, 32'h0);
    tick(2);
    chk("pull", pull_down_o, 32'h3FF);
    $display("test protection done");
    wrap_up();
  end
endmodule : tb
bind lsp_ctrl lsp_ctrl_asserts #(
  .NREG     (NREG),
  .DEBOUNCE (DEBOUNCE)
) lsp_ctrl_asserts_inst (
  .clk_i                   (clk_i),
  .rst_i                   (rst_i),
  .ce_i                    (ce_i),
  .wb_cyc_i                (wb_cyc_i),
  .wb_stb_i                (wb_stb_i),
  .wb_we_i                 (wb_we_i),
  .wb_adr_i                (wb_adr_i),
  .wb_sel_i                (wb_sel_i),
  .wb_dat_i                (wb_dat_i),
  .wb_ack_o                (wb_ack_o),
  .overload_i              (overload_i),
  .regulator_on_o          (regulator_on_o),
  .pull_down_o             (pull_down_o),
  .video_bypass_o          (video_bypass_o),
  .video_low_power_o       (video_low_power_o),
  .camera_external_drive_o (camera_external_drive_o),
  .video_supply_mv_o       (video_supply_mv_o),
  .card_supply_mv_o        (card_supply_mv_o),
  .short_fault_irq_o       (short_fault_irq_o)
);
`default_nettype wire
